// ===== core/hfo_pkg.sv
/*
  Shared constants for the high-frequency oscillator control block: register
  addresses, field positions, reset values, divider codes and timing counts.
  Assumes the block is clocked from the oscillator clock at the rate below.
*/
package hfo_pkg;

  localparam logic [7:0] ADDR_CTRL   = 8'hb2;
  localparam logic [7:0] ADDR_TRIM   = 8'hb3;
  localparam logic [7:0] ADDR_COMPAT = 8'hb9;

  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_READY_BIT = 6;
  localparam int CTRL_SUSP_BIT  = 5;
  localparam int CTRL_DIV_LSB   = 0;
  localparam int TRIM_W         = 7;
  localparam int DIV_W          = 2;

  localparam logic             RST_EN     = 1'b1;
  localparam logic             RST_READY  = 1'b1;
  localparam logic [DIV_W-1:0] RST_DIV    = 2'h0;
  localparam logic [7:0]       COMPAT_VAL = 8'he0;

  localparam logic [DIV_W-1:0] DIV_BY8 = 2'h0;
  localparam logic [DIV_W-1:0] DIV_BY4 = 2'h1;
  localparam logic [DIV_W-1:0] DIV_BY2 = 2'h2;
  localparam logic [DIV_W-1:0] DIV_BY1 = 2'h3;

  localparam int PRE_DIV  = 4;
  localparam int DIVCNT_W = 5;

  localparam logic [2:0] SRC_HF_SCALED = 3'h0;
  localparam logic [2:0] SRC_HF_HALF   = 3'h2;
  localparam logic [2:0] SRC_HF_FULL   = 3'h3;

  localparam int CLK_FREQ_MHZ   = 125;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SETTLE_W       = 8;

endpackage

// ===== core/hfo_suspend_latch.sv
/*
  Suspend flag of the oscillator. Software sets it on the running clock;
  any wake event clears it without a clock, since the clock is halted then.
  Assumes wake inputs are clean levels or pulses from logic that keeps running.
*/
`timescale 1ns/100ps
module hfo_suspend_latch (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic set_in,
  input  wire logic wake_p0_match_in,
  input  wire logic wake_p1_match_in,
  input  wire logic wake_timer3_ovf_in,
  input  wire logic wake_usb_resume_in,
  output logic      suspend_out
);

  logic wake_any;
  logic clr_n;

  // Any wake source ends suspend whether or not it also raises an interrupt.
  assign wake_any = wake_p0_match_in | wake_p1_match_in | wake_timer3_ovf_in | wake_usb_resume_in; // [R8]
  assign clr_n    = arst_n_in & ~wake_any; // [R20]

  // The clear acts without a clock edge, so a halted oscillator still wakes.
  always_ff @(posedge mclk_in or negedge clr_n)
  begin
    if (!clr_n)
    begin
      suspend_out <= 1'b0; // [R7]
    end
    else if (set_in)
    begin
      suspend_out <= 1'b1; // [R6]
    end
  end

endmodule

// ===== core/hfo_ctrl.sv
/*
  Control logic of the internal high-frequency oscillator: trim and control
  registers on the special function register port, settling ready flag,
  fixed divide-by-4 and selectable post-divider, suspend with clock gating,
  and a read-only multiplier compatibility register.
  Assumes the processor drives one write or read strobe per access, the
  factory trim value is stable from reset, and system_clock_source_sel comes from
  the clock select register on this clock.
*/
// Functional notes
// R1: Oscillator selected as system clock after reset.
// R2: Trim preset from factory calibration for 48 MHz.
// R3: Divide by 4, then by 1/2/4/8.
// R4: Reset divide factor is 8.
// R5: Divider codes 00=/8 01=/4 10=/2 11=/1.
// R6: Writing suspend bit 5 halts the oscillator.
// R7: Suspended clocks stay stopped until wake event. Code gates them only for source codes 000, 010 and 011.
// R8: Any wake event restarts oscillator and clocks.
// R9: Processor resumes at next instruction after wake.
// R10: Trim zero fastest, all ones slowest.
// R11: Trim top bit reads zero, ignores writes.
// R12: Trim reset value is factory calibration.
// R13: Control bit 7 enables oscillator, resets 1.
// R14: Bit 6 reads 1 only at programmed frequency.
// R15: Control bits 4 to 2 read zero.
// R16: Compatibility register read-only, reports working multiplier.
// R17: Multiplier enable, init, ready read one.
// R18: Multiplier input select reads 00.
// R19: Source code 000 gives divided oscillator clock.
// R20: Wake detection clockless, gated restart glitch-free.
`timescale 1ns/100ps
module hfo_ctrl #(
  parameter int SETTLE_CYC = hfo_pkg::SETTLE_CYCLES
) (
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [6:0] trim_cal_in,
  input  wire logic [2:0] system_clock_source_sel_in,
  input  wire logic       wake_p0_match_in,
  input  wire logic       wake_p1_match_in,
  input  wire logic       wake_timer3_ovf_in,
  input  wire logic       wake_usb_resume_in,
  output logic [7:0]      sfr_rdata_out,
  output logic            sfr_rvalid_out,
  output logic            hf_osc_enable_out,
  output logic            hf_osc_suspend_out,
  output logic [6:0]      hf_osc_trim_out,
  output logic            hf_freq_ready_out,
  output logic            hf_system_clock_sel_out,
  output logic            system_clock_tick_out,
  output logic            core_clk_en_out,
  output logic            periph_clk_en_out
);

  typedef struct packed {
    logic                                    en;
    logic [hfo_pkg::DIV_W-1:0]               div_sel;
    logic [hfo_pkg::TRIM_W-1:0]              trim;
    logic                                    cal_done;
    logic [hfo_pkg::SETTLE_W-1:0]            settle;
    logic                                    ready;
    logic [hfo_pkg::DIVCNT_W-1:0]            div_cnt;
    logic                                    tick;
    logic [2:0]                              susp_sync;
    logic                                    susp_st;
    logic                                    gate_en;
    logic                                    hf_sel;
    logic [7:0]                              rdata;
    logic                                    rvalid;
  } hfo_state_s;

  localparam logic [hfo_pkg::SETTLE_W-1:0] SETTLE_LOAD = hfo_pkg::SETTLE_W'(SETTLE_CYC);

  hfo_state_s state_r;
  hfo_state_s state_nxt;
  logic       suspend_flag;
  logic       suspend_set;
  logic       wr_ctrl;
  logic       wr_trim;
  logic       osc_off;
  logic       restart;
  logic       src_internal;

  // Terminal count of the combined prescale and post-divide counter.
  function automatic logic [hfo_pkg::DIVCNT_W-1:0] div_last(input logic [hfo_pkg::DIV_W-1:0] sel);
    int ratio;
    ratio = 1;
    unique case (sel)
      hfo_pkg::DIV_BY8: ratio = 8;
      hfo_pkg::DIV_BY4: ratio = 4;
      hfo_pkg::DIV_BY2: ratio = 2;
      hfo_pkg::DIV_BY1: ratio = 1;
    endcase
    return hfo_pkg::DIVCNT_W'(hfo_pkg::PRE_DIV * ratio - 1); // [R3] [R5]
  endfunction

  // Register read view, with reserved bits forced to zero.
  function automatic logic [7:0] read_view(input logic [7:0] addr, input hfo_state_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      hfo_pkg::ADDR_CTRL:
      begin
        v[hfo_pkg::CTRL_EN_BIT]    = s.en;
        v[hfo_pkg::CTRL_READY_BIT] = s.ready; // [R14]
        v[hfo_pkg::CTRL_SUSP_BIT]  = s.susp_st;
        v[hfo_pkg::CTRL_DIV_LSB +: hfo_pkg::DIV_W] = s.div_sel; // [R15]
      end
      hfo_pkg::ADDR_TRIM:   v = {1'b0, s.trim}; // [R11]
      hfo_pkg::ADDR_COMPAT: v = hfo_pkg::COMPAT_VAL; // [R16] [R17] [R18]
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  assign wr_ctrl      = sfr_wr_in && (sfr_addr_in == hfo_pkg::ADDR_CTRL);
  assign wr_trim      = sfr_wr_in && (sfr_addr_in == hfo_pkg::ADDR_TRIM);
  assign suspend_set  = wr_ctrl && sfr_wdata_in[hfo_pkg::CTRL_SUSP_BIT]; // [R6]
  assign src_internal = (system_clock_source_sel_in == hfo_pkg::SRC_HF_SCALED) ||
                        (system_clock_source_sel_in == hfo_pkg::SRC_HF_HALF) ||
                        (system_clock_source_sel_in == hfo_pkg::SRC_HF_FULL);

  hfo_suspend_latch u_susp (
    .mclk_in            (mclk_in),
    .arst_n_in          (arst_n_in),
    .set_in             (suspend_set),
    .wake_p0_match_in   (wake_p0_match_in),
    .wake_p1_match_in   (wake_p1_match_in),
    .wake_timer3_ovf_in (wake_timer3_ovf_in),
    .wake_usb_resume_in (wake_usb_resume_in),
    .suspend_out        (suspend_flag)
  );

  always_comb
  begin
    state_nxt = state_r;
    osc_off   = !state_r.en || state_r.susp_st;
    restart   = 1'b0;

    // The suspend flag clears asynchronously, so it is resynchronised here.
    state_nxt.susp_sync = {state_r.susp_sync[1:0], suspend_flag};
    if (state_r.susp_sync[2] == state_r.susp_sync[1])
    begin
      state_nxt.susp_st = state_r.susp_sync[2];
    end

    // Factory trim is caught on the first edge after reset release.
    if (!state_r.cal_done)
    begin
      state_nxt.trim     = trim_cal_in; // [R2] [R12]
      state_nxt.cal_done = 1'b1;
    end
    else if (wr_trim)
    begin
      state_nxt.trim = sfr_wdata_in[hfo_pkg::TRIM_W-1:0]; // [R10] [R11]
      restart        = (sfr_wdata_in[hfo_pkg::TRIM_W-1:0] != state_r.trim);
    end

    if (wr_ctrl)
    begin
      state_nxt.en      = sfr_wdata_in[hfo_pkg::CTRL_EN_BIT]; // [R13]
      state_nxt.div_sel = sfr_wdata_in[hfo_pkg::CTRL_DIV_LSB +: hfo_pkg::DIV_W]; // [R5]
      restart           = restart || (sfr_wdata_in[hfo_pkg::CTRL_EN_BIT] && !state_r.en);
    end

    // Ready drops while the oscillator is off or retuning, then settles.
    if (osc_off || restart)
    begin
      state_nxt.ready  = 1'b0; // [R14]
      state_nxt.settle = SETTLE_LOAD;
    end
    else if (state_r.settle != '0)
    begin
      state_nxt.settle = state_r.settle - 1'b1;
      state_nxt.ready  = (state_r.settle == 1);
    end

    // Divided system clock as a one-cycle tick per output period.
    state_nxt.tick = 1'b0;
    if (osc_off)
    begin
      state_nxt.div_cnt = '0;
    end
    else if (state_r.div_cnt == '0)
    begin
      state_nxt.div_cnt = div_last(state_r.div_sel); // [R3]
      state_nxt.tick    = 1'b1;
    end
    else
    begin
      state_nxt.div_cnt = state_r.div_cnt - 1'b1;
    end

    // Gate enables change only on a clock edge, so gated clocks restart cleanly.
    state_nxt.gate_en = !(state_r.susp_st && src_internal); // [R7] [R9] [R20]
    state_nxt.hf_sel  = (system_clock_source_sel_in == hfo_pkg::SRC_HF_SCALED); // [R1] [R19]

    state_nxt.rvalid = sfr_rd_in;
    if (sfr_rd_in)
    begin
      state_nxt.rdata = read_view(sfr_addr_in, state_r);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r           <= '0;
      state_r.en        <= hfo_pkg::RST_EN; // [R13]
      state_r.ready     <= hfo_pkg::RST_READY;
      state_r.div_sel   <= hfo_pkg::RST_DIV; // [R4]
      state_r.gate_en   <= 1'b1;
      state_r.hf_sel    <= 1'b1; // [R1]
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sfr_rdata_out         = state_r.rdata;
  assign sfr_rvalid_out        = state_r.rvalid;
  assign hf_osc_enable_out     = state_r.en;
  assign hf_osc_suspend_out    = suspend_flag; // [R6]
  assign hf_osc_trim_out       = state_r.trim; // [R10]
  assign hf_freq_ready_out     = state_r.ready;
  assign hf_system_clock_sel_out     = state_r.hf_sel;
  assign system_clock_tick_out = state_r.tick;
  assign core_clk_en_out       = state_r.gate_en; // [R8]
  assign periph_clk_en_out     = state_r.gate_en; // [R8]

endmodule

// ===== bench/hfo_ctrl_assertions.sv
/*
  Port checker for hfo_ctrl, bound to every instance of it.
  Assumes wake inputs stay low around a write of the suspend bit.
*/
`timescale 1ns/100ps
module hfo_chk (
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [2:0] system_clock_source_sel_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       hf_osc_enable_out,
  input wire logic       hf_osc_suspend_out,
  input wire logic       hf_freq_ready_out,
  input wire logic       hf_system_clock_sel_out,
  input wire logic       system_clock_tick_out,
  input wire logic       core_clk_en_out,
  input wire logic       periph_clk_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic rd_c = sfr_rd_in && sfr_addr_in == hfo_pkg::ADDR_CTRL;
  wire logic wr_c = sfr_wr_in && sfr_addr_in == hfo_pkg::ADDR_CTRL;
  sequence s_held;
    hf_osc_suspend_out [*6];
  endsequence
  sequence s_off;
    !core_clk_en_out && !periph_clk_en_out && !system_clock_tick_out;
  endsequence
  AST_COMPAT:
    assert property (sfr_rd_in && sfr_addr_in == hfo_pkg::ADDR_COMPAT |=> sfr_rdata_out == 8'he0)
      else $error("compat read wrong");
  AST_TRIM_TOP:
    assert property (sfr_rd_in && sfr_addr_in == hfo_pkg::ADDR_TRIM |=> !sfr_rdata_out[7])
      else $error("trim top bit set");
  AST_CTRL_ZERO:
    assert property (rd_c |=> sfr_rdata_out[4:2] == 3'h0)
      else $error("control unused bits set");
  AST_CTRL_FLAGS:
    assert property (rd_c |=> sfr_rdata_out[7:6] == {$past(hf_osc_enable_out), $past(hf_freq_ready_out)})
      else $error("control flags wrong");
  AST_SUSP_SET:
    assert property (wr_c && sfr_wdata_in[5] |=> hf_osc_suspend_out)
      else $error("suspend not set");
  AST_SUSP_GATE:
    assert property (s_held ##0 system_clock_source_sel_in == 3'h0 |-> s_off)
      else $error("clocks run in suspend");
  AST_WAKE:
    assert property ($fell(hf_osc_suspend_out) |-> ##[1:8] core_clk_en_out && periph_clk_en_out)
      else $error("clocks not restarted");
  AST_SRC:
    assert property (1 |=> hf_system_clock_sel_out == ($past(system_clock_source_sel_in) == 3'h0))
      else $error("source select wrong");
  AST_DISABLE:
    assert property (wr_c && !sfr_wdata_in[7] |=> !hf_osc_enable_out ##[0:2] !hf_freq_ready_out)
      else $error("disable not taken");
endmodule

bind hfo_ctrl hfo_chk u_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .system_clock_source_sel_in(system_clock_source_sel_in), .sfr_rdata_out(sfr_rdata_out),
  .hf_osc_enable_out(hf_osc_enable_out), .hf_osc_suspend_out(hf_osc_suspend_out),
  .hf_freq_ready_out(hf_freq_ready_out), .hf_system_clock_sel_out(hf_system_clock_sel_out),
  .system_clock_tick_out(system_clock_tick_out), .core_clk_en_out(core_clk_en_out),
  .periph_clk_en_out(periph_clk_en_out));

// ===== bench/hfo_consumer.sv
/*
  Clock consumer model: counts gated system clock ticks and the spacing of the last two.
  Assumes tick pulses last one cycle of the oscillator clock.
*/
`timescale 1ns/100ps
module hfo_consumer (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic tick_in,
  input  wire logic clk_en_in,
  output int        ticks_out,
  output int        period_out
);
  int gap;
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      gap <= 0;
      ticks_out <= 0;
      period_out <= 0;
    end
    else if (tick_in && clk_en_in)
    begin
      period_out <= gap + 1;
      gap <= 0;
      ticks_out <= ticks_out + 1;
    end
    else
      gap <= gap + 1;
endmodule

// ===== bench/tb.sv
/*
  Self-checking bench for hfo_ctrl: register access, divider, enable and suspend.
  Assumes a short settle count so the ready flag returns within a few cycles.
*/
`timescale 1ns/100ps
module tb;
  logic       mclk, rst_n, wr, rd, rvalid, en, susp, rdy, sel, tick, core_en, per_en;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] trim;
  logic [2:0] src;
  logic [3:0] wake;
  int         mismatches, num_checks, ticks, period, t0, i;

  hfo_ctrl #(.SETTLE_CYC(4)) dut (.mclk_in(mclk), .arst_n_in(rst_n), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .trim_cal_in(7'h55),
    .system_clock_source_sel_in(src), .wake_p0_match_in(wake[0]), .wake_p1_match_in(wake[1]),
    .wake_timer3_ovf_in(wake[2]), .wake_usb_resume_in(wake[3]), .sfr_rdata_out(rdata),
    .sfr_rvalid_out(rvalid), .hf_osc_enable_out(en), .hf_osc_suspend_out(susp),
    .hf_osc_trim_out(trim), .hf_freq_ready_out(rdy), .hf_system_clock_sel_out(sel),
    .system_clock_tick_out(tick), .core_clk_en_out(core_en), .periph_clk_en_out(per_en));
  hfo_consumer u_cons (.mclk_in(mclk), .arst_n_in(rst_n), .tick_in(tick), .clk_en_in(core_en),
    .ticks_out(ticks), .period_out(period));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(rvalid, 1);
    chk(rdata, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    cyc(5000);
    mismatches++;
    test_done;
  end
  initial
  begin
    {rst_n, wr, rd, addr, wdata, src, wake} = '0;
    cyc(4);
    rst_n = 1'b1;
    cyc(10);
    rreg(8'hb2, 8'hc0);
    rreg(8'hb3, 8'h55);
    rreg(8'hb9, 8'he0);
    rreg(8'ha0, 8'h00);
    chk(sel, 1);
    $display("test reset done");
    wreg(8'hb2, 8'h9f);
    rreg(8'hb2, 8'hc3);
    wreg(8'hb3, 8'hff);
    chk(trim, 7'h7f);
    rreg(8'hb3, 8'h7f);
    wreg(8'hb9, 8'h00);
    rreg(8'hb9, 8'he0);
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      wreg(8'hb2, 8'h80 | i[7:0]);
      cyc(100);
      chk(period, 32 >> i);
    end
    $display("test divider done");
    wreg(8'hb2, 8'h03);
    cyc(3);
    chk({en, rdy}, 0);
    wreg(8'hb2, 8'h83);
    cyc(10);
    chk({en, rdy}, 3);
    $display("test enable done");
    for (i = 0; i < 4; i++)
    begin
      wreg(8'hb2, 8'ha3);
      cyc(10);
      t0 = ticks;
      chk({core_en, per_en}, 0);
      cyc(20);
      chk(ticks, t0);
      wake[i] = 1'b1;
      cyc(1);
      wake[i] = 1'b0;
      chk(susp, 0);
      cyc(12);
      chk({core_en, per_en, rdy}, 7);
    end
    $display("test suspend done");
    src = 3'h1;
    wreg(8'hb2, 8'ha3);
    cyc(10);
    chk({core_en, sel}, 2);
    wake[0] = 1'b1;
    cyc(1);
    wake[0] = 1'b0;
    src = 3'h0;
    $display("test external done");
    src = 3'h2;
    wreg(8'hb2, 8'ha3);
    cyc(10);
    chk({core_en, per_en, sel}, 0);
    wake[3] = 1'b1;
    cyc(1);
    wake[3] = 1'b0;
    cyc(12);
    chk({core_en, per_en}, 3);
    src = 3'h0;
    $display("test derived source done");
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    rreg(8'hb2, 8'hc0);
    rreg(8'hb3, 8'h55);
    chk(sel, 1);
    $display("test second reset done");
    test_done;
  end
endmodule
